// ==== rtl/nffu_pkg.sv ====
// package: opcodes, carriers and constants of the numeric format unit
package nffu_pkg;

  typedef enum logic [2:0] {
    op_int_div,
    op_int_sqrt,
    op_bin_to_bcd,
    op_bcd_to_bin,
    op_point_oct,
    op_float_mul,
    op_bin_to_dec_float_convert,
    op_dec_to_bin_float_convert
  } nffu_op_e;

  typedef enum logic [2:0] {
    st_idle,
    st_scale,
    st_dec_norm,
    st_dec_out,
    st_bin_norm,
    st_bin_out
  } nffu_state_e;

  // operands arrive as register pairs: lo = lower numbered register
  typedef struct packed {
    nffu_op_e    op;
    logic [15:0] a_lo;
    logic [15:0] a_hi;
    logic [15:0] b_lo;
    logic [15:0] b_hi;
  } nffu_req_s;

  typedef struct packed {
    logic [15:0] lo;
    logic [15:0] hi;
  } nffu_res_s;

  typedef struct packed {
    logic zero_result_flag;
    logic underflow_borrow_flag;
    logic overflow_carry_flag;
  } nffu_flags_s;

  localparam int                 WIDE_W        = 40;
  localparam int                 SCALE_HI_BIT  = 36;
  localparam int                 SCALE_LO_BIT  = 32;
  localparam int                 SIGN_BIT      = 31;
  localparam int                 EXP_LSB       = 23;
  localparam int                 MANT_TOP      = 24;
  localparam int                 PROD_DROP     = 8;
  localparam int                 BCD_DIGITS    = 5;
  localparam int                 OCT_DIGITS    = 6;
  localparam logic signed [11:0] FLT_MUL_OFS   = 12'sh124;
  localparam logic signed [11:0] FLT_PACK_OFS  = 12'sh096;
  localparam logic signed [11:0] FLT_EXP_MAX   = 12'sh0ff;
  localparam logic [31:0]        FLT_MAX_MAG   = 32'h7f7fffff;
  localparam logic [WIDE_W-1:0]  WIDE_TEN      = 40'h000000000a;
  localparam logic [WIDE_W-1:0]  WIDE_HALF     = 40'h0000000005;
  localparam logic [WIDE_W-1:0]  DEC_MANT_MIN  = 40'h00000003e8;
  localparam logic [WIDE_W-1:0]  DEC_ROUND_LIM = 40'h0000002710;
  localparam logic [WIDE_W-1:0]  DEC_TRUNC_LIM = 40'h00000186a0;
  localparam logic [15:0]        DEC_SAT_MANT  = 16'h0d4a;
  localparam logic signed [7:0]  DEC_EXP_MIN   = 8'shd7;
  localparam logic signed [7:0]  DEC_EXP_MAX   = 8'sh23;

endpackage

// ==== rtl/nffu_unit.sv ====
// numeric format unit: integer, bcd, octal and float conversion datapath
// Summary of operation
// - negative integers are two's complement in every word
// - decimal or hex operands are held and processed as plain binary
// - packed decimal puts one digit per nibble, least digit lowest
// - point numbers count in base eight, digits 8 and 9 never appear
// - integer divide yields whole quotient plus separate whole remainder
// - integer square root drops the fraction
// - binary float uses two registers, higher one holds upper 16 bits
// - float word: sign bit 31, 8-bit exponent bias 127, 23-bit fraction
// - float sign is a plain flag, magnitude never complemented
// - float results span 1175494e-44 to 3402823e32 in magnitude
// - zero flag set only when the float result is exactly zero
// - borrow flag set when nonzero result is below smallest unit
// - carry flag set when result magnitude exceeds the largest value
// - arithmetic is binary float; decimal float only for conversion
// - decimal float: lower register mantissa, higher register exponent
// - decimal mantissa is 1000 to 9999 or zero, rescaled via exponent
// - decimal exponent is a signed power of ten, -41 to +35
// - sign is top bit of mantissa and exponent, both two's complement
// - decimal float spans 1175e-41 to 3402e35 in magnitude
// - separate explicit operations convert binary to decimal and back
`timescale 1ns/1ps
module nffu_unit (
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire logic                  req_valid,
  input  wire nffu_pkg::nffu_req_s   req,
  output      logic                  busy,
  output      logic                  done,
  output      nffu_pkg::nffu_res_s   result,
  output      nffu_pkg::nffu_flags_s flags
);
  import nffu_pkg::*;

  nffu_state_e        state;
  nffu_state_e        next_state;
  logic [WIDE_W-1:0]  w;
  logic [WIDE_W-1:0]  next_w;
  logic signed [11:0] e2;
  logic signed [11:0] next_e2;
  logic signed [7:0]  d;
  logic signed [7:0]  next_d;
  logic               neg;
  logic               next_neg;
  logic               f2d;
  logic               next_f2d;
  logic               next_busy;
  logic               next_done;
  nffu_res_s          next_result;
  nffu_flags_s        next_flags;

  // integer paths, all single cycle
  wire signed [15:0] div_a = req.a_lo;
  wire signed [15:0] div_b = req.a_hi;
  wire               div_by_zero = (div_b == 16'sh0000);
  // truncating quotient, remainder keeps the dividend's sign
  wire signed [15:0] div_q = div_by_zero ? 16'sh0000 : div_a / div_b;
  wire signed [15:0] div_r = div_by_zero ? 16'sh0000 : div_a % div_b;

  function automatic logic [15:0] int_sqrt(input logic [31:0] v);
    logic [15:0] r;
    logic [15:0] t;
    logic [31:0] sq;
    r = 16'h0000;
    for (int i = 15; i >= 0; i--) begin
      t  = r | (16'h0001 << i);
      sq = {16'h0000, t} * {16'h0000, t};
      if (sq <= v) begin
        r = t;
      end
    end
    return r;
  endfunction

  wire [15:0] sqrt_root = int_sqrt({req.a_hi, req.a_lo});

  wire [4*BCD_DIGITS-1:0] bcd_digits;
  wire [15:0]             bcd_part [BCD_DIGITS];
  wire [4*OCT_DIGITS-1:0] oct_digits;
  wire [3*OCT_DIGITS-1:0] oct_src = {2'b00, req.a_lo};

  for (genvar g = 0; g < OCT_DIGITS; g++) begin : g_digit
    // each point digit is three bits, so 8 and 9 cannot occur
    assign oct_digits[4*g +: 4] = {1'b0, oct_src[3*g +: 3]};
    if (g < BCD_DIGITS) begin : g_bcd
      assign bcd_digits[4*g +: 4] = 4'((req.a_lo / 16'(10**g)) % 16'h000a);
      if (g < 4) begin : g_back
        assign bcd_part[g] = 16'(req.a_lo[4*g +: 4] * 16'(10**g));
      end else begin : g_none
        assign bcd_part[g] = 16'h0000;
      end
    end
  end

  wire [15:0] bcd_value = bcd_part[0] + bcd_part[1] + bcd_part[2] + bcd_part[3];

  // float operand fields
  wire [31:0] a_f    = {req.a_hi, req.a_lo};
  wire [31:0] b_f    = {req.b_hi, req.b_lo};
  wire [7:0]  a_exp  = a_f[30:EXP_LSB];
  wire [7:0]  b_exp  = b_f[30:EXP_LSB];
  wire [47:0] prod   = {1'b1, a_f[22:0]} * {1'b1, b_f[22:0]};
  wire signed [11:0] e2_mul = $signed({4'h0, a_exp}) + $signed({4'h0, b_exp}) - FLT_MUL_OFS;
  wire signed [11:0] e2_f2d = $signed({4'h0, a_exp}) - FLT_PACK_OFS;
  wire [15:0] mant_mag = req.a_lo[15] ? 16'(-req.a_lo) : req.a_lo;

  // shared wide scaling datapath
  wire [WIDE_W-1:0] w_div10 = w / WIDE_TEN;
  wire [WIDE_W-1:0] w_mul10 = w * WIDE_TEN;
  wire [WIDE_W-1:0] w_rnd10 = (w + WIDE_HALF) / WIDE_TEN;
  wire              w_zero  = (w == '0);
  wire              w_hi    = |w[WIDE_W-1:SCALE_HI_BIT];
  wire              w_lo    = |w[WIDE_W-1:SCALE_LO_BIT];
  wire signed [11:0] bexp   = e2 + FLT_PACK_OFS;
  wire [15:0]       mant_out = neg ? 16'(-w[15:0]) : w[15:0];

  always_comb begin
    next_state  = state;
    next_w      = w;
    next_e2     = e2;
    next_d      = d;
    next_neg    = neg;
    next_f2d    = f2d;
    next_busy   = busy;
    next_done   = 1'b0;
    next_result = result;
    next_flags  = flags;
    unique case (state)
      st_idle: begin
        if (req_valid) begin
          unique case (req.op)
            op_int_div: begin
              next_result.lo = div_q;
              next_result.hi = div_r;
              next_done      = 1'b1;
            end
            op_int_sqrt: begin
              next_result.lo = sqrt_root;
              next_result.hi = 16'h0000;
              next_done      = 1'b1;
            end
            op_bin_to_bcd: begin
              next_result.lo = bcd_digits[15:0];
              next_result.hi = {12'h000, bcd_digits[19:16]};
              next_done      = 1'b1;
            end
            op_bcd_to_bin: begin
              next_result.lo = bcd_value;
              next_result.hi = 16'h0000;
              next_done      = 1'b1;
            end
            op_point_oct: begin
              next_result.lo = oct_digits[15:0];
              next_result.hi = {8'h00, oct_digits[23:16]};
              next_done      = 1'b1;
            end
            op_float_mul: begin
              next_neg   = a_f[SIGN_BIT] ^ b_f[SIGN_BIT];
              // low product bits dropped so the product fits the wide register
              next_w     = (a_exp == 8'h00 || b_exp == 8'h00) ? '0 : prod[47:PROD_DROP];
              next_e2    = e2_mul;
              next_state = st_bin_norm;
              next_busy  = 1'b1;
            end
            op_bin_to_dec_float_convert: begin
              next_neg   = a_f[SIGN_BIT];
              next_w     = (a_exp == 8'h00) ? '0 : {16'h0000, 1'b1, a_f[22:0]};
              next_e2    = e2_f2d;
              next_d     = 8'sh00;
              next_f2d   = 1'b1;
              next_state = st_scale;
              next_busy  = 1'b1;
            end
            op_dec_to_bin_float_convert: begin
              next_neg   = req.a_lo[15];
              next_w     = {24'h000000, mant_mag};
              next_e2    = 12'sh000;
              next_d     = req.a_hi[7:0];
              next_f2d   = 1'b0;
              next_state = st_scale;
              next_busy  = 1'b1;
            end
          endcase
        end
      end
      st_scale: begin
        // headroom bits keep about 32 significant bits through every step
        if (w_zero || (f2d ? (e2 == 12'sh000) : (d == 8'sh00))) begin
          next_state = f2d ? st_dec_norm : st_bin_norm;
        end else if (f2d ? (e2 > 12'sh000) : (d < 8'sh00)) begin
          if (w_hi || (!f2d && w_lo)) begin
            next_w = w_div10;
            next_d = d + 8'sh01;
          end else begin
            next_w  = w << 1;
            next_e2 = e2 - 12'sh001;
          end
        end else if (w_lo || (!f2d && w_hi)) begin
          next_w  = w >> 1;
          next_e2 = e2 + 12'sh001;
        end else begin
          next_w = w_mul10;
          next_d = d - 8'sh01;
        end
      end
      st_dec_norm: begin
        if (w_zero) begin
          next_state = st_dec_out;
        end else if (w >= DEC_TRUNC_LIM) begin
          next_w = w_div10;
          next_d = d + 8'sh01;
        end else if (w >= DEC_ROUND_LIM) begin
          next_w = w_rnd10;
          next_d = d + 8'sh01;
        end else if (w < DEC_MANT_MIN) begin
          next_w = w_mul10;
          next_d = d - 8'sh01;
        end else begin
          next_state = st_dec_out;
        end
      end
      st_dec_out: begin
        next_flags = '0;
        if (w_zero) begin
          next_result = '0;
          next_flags.zero_result_flag = 1'b1;
        end else if (d > DEC_EXP_MAX) begin
          next_result.lo = neg ? 16'(-DEC_SAT_MANT) : DEC_SAT_MANT;
          next_result.hi = {{8{DEC_EXP_MAX[7]}}, DEC_EXP_MAX};
          next_flags.overflow_carry_flag = 1'b1;
        end else if (d < DEC_EXP_MIN) begin
          next_result = '0;
          next_flags.underflow_borrow_flag = 1'b1;
        end else begin
          next_result.lo = mant_out;
          next_result.hi = {{8{d[7]}}, d};
        end
        next_done  = 1'b1;
        next_busy  = 1'b0;
        next_state = st_idle;
      end
      st_bin_norm: begin
        if (w_zero) begin
          next_state = st_bin_out;
        end else if (|w[WIDE_W-1:MANT_TOP]) begin
          next_w  = w >> 1;
          next_e2 = e2 + 12'sh001;
        end else if (!w[EXP_LSB]) begin
          next_w  = w << 1;
          next_e2 = e2 - 12'sh001;
        end else begin
          next_state = st_bin_out;
        end
      end
      st_bin_out: begin
        next_flags = '0;
        if (w_zero) begin
          next_result = '0;
          next_flags.zero_result_flag = 1'b1;
        end else if (bexp >= FLT_EXP_MAX) begin
          {next_result.hi, next_result.lo} = {neg, FLT_MAX_MAG[30:0]};
          next_flags.overflow_carry_flag = 1'b1;
        end else if (bexp <= 12'sh000) begin
          next_result = '0;
          next_flags.underflow_borrow_flag = 1'b1;
        end else begin
          // sign-magnitude pack, upper half into the higher register
          {next_result.hi, next_result.lo} = {neg, bexp[7:0], w[22:0]};
        end
        next_done  = 1'b1;
        next_busy  = 1'b0;
        next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state  <= st_idle;
      w      <= '0;
      e2     <= 12'sh000;
      d      <= 8'sh00;
      neg    <= 1'b0;
      f2d    <= 1'b0;
      busy   <= 1'b0;
      done   <= 1'b0;
      result <= '0;
      flags  <= '0;
    end else begin
      state  <= next_state;
      w      <= next_w;
      e2     <= next_e2;
      d      <= next_d;
      neg    <= next_neg;
      f2d    <= next_f2d;
      busy   <= next_busy;
      done   <= next_done;
      result <= next_result;
      flags  <= next_flags;
    end
  end

endmodule

// ==== testbench/nffu_unit_sva.sv ====
// checker: port-level timing and flag relations of the numeric format unit
`timescale 1ns/1ps
module nffu_unit_sva (
  input wire logic                  sys_clk,
  input wire logic                  reset,
  input wire logic                  req_valid,
  input wire nffu_pkg::nffu_req_s   req,
  input wire logic                  busy,
  input wire logic                  done,
  input wire nffu_pkg::nffu_res_s   result,
  input wire nffu_pkg::nffu_flags_s flags
);
  import nffu_pkg::*;
  wire logic take   = req_valid && !busy;
  wire logic int_op = req.op inside {op_int_div, op_int_sqrt, op_bin_to_bcd,
                                     op_bcd_to_bin, op_point_oct};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_int_answer; take && int_op |=> done && !busy; endproperty
  a_int_answer: assert property (p_int_answer) else $error("integer op not done in one cycle");
  property p_flt_start; take && !int_op |=> busy && !done; endproperty
  a_flt_start: assert property (p_flt_start) else $error("float op did not go busy");
  // conversions iterate up to about 210 cycles, so 300 leaves margin
  property p_flt_bound; $rose(busy) |-> ##[1:300] done; endproperty
  a_flt_bound: assert property (p_flt_bound) else $error("float op never finished");
  property p_busy_end; $fell(busy) |-> done; endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy fell without done");
  property p_flags_hold; !done |-> $stable(flags); endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("flags moved without a result");
  property p_int_flags; done && !$past(busy) |-> $stable(flags); endproperty
  a_int_flags: assert property (p_int_flags) else $error("integer op touched flags");
  property p_res_hold; !done |-> $stable(result); endproperty
  a_res_hold: assert property (p_res_hold) else $error("result moved without done");
  // flags hold across integer ops, so only a float completion is judged
  property p_zero_res; $fell(busy) && flags.zero_result_flag |-> result == '0; endproperty
  a_zero_res: assert property (p_zero_res) else $error("zero flag on nonzero result");
  property p_borrow_res; $fell(busy) && flags.underflow_borrow_flag |-> result == '0; endproperty
  a_borrow_res: assert property (p_borrow_res) else $error("underflow not flushed");
  property p_carry_res;
    $fell(busy) && flags.overflow_carry_flag |->
      result.lo inside {16'hffff, 16'h0d4a, 16'hf2b6} &&
      result.hi inside {16'h7f7f, 16'hff7f, 16'h0023};
  endproperty
  a_carry_res: assert property (p_carry_res) else $error("overflow not saturated");

  c_zero: cover property (done && flags.zero_result_flag);
  c_borrow: cover property (done && flags.underflow_borrow_flag);
  c_carry: cover property (done && flags.overflow_carry_flag);
endmodule

bind nffu_unit nffu_unit_sva u_sva (.sys_clk(sys_clk), .reset(reset), .req_valid(req_valid),
  .req(req), .busy(busy), .done(done), .result(result), .flags(flags));

// ==== testbench/nffu_core_model.sv ====
// partner: instruction core issuing one request at a time to the unit
`timescale 1ns/1ps
module nffu_core_model (
  input  wire logic                sys_clk,
  input  wire logic                reset,
  input  wire logic                go,
  input  wire nffu_pkg::nffu_req_s go_req,
  input  wire logic                busy,
  output      logic                req_valid,
  output      nffu_pkg::nffu_req_s req
);
  import nffu_pkg::*;
  wire logic launch = go && !busy && !req_valid;
  // request lasts one cycle; idle bus toggles so stale operands never look valid
  always @(negedge sys_clk or posedge reset) begin
    if (reset) begin
      req_valid <= 1'b0;
      req       <= '0;
    end else if (launch) begin
      req_valid <= 1'b1;
      req       <= go_req;
    end else begin
      req_valid <= 1'b0;
      req       <= ~req;
    end
  end
endmodule

// ==== testbench/nffu_unit_tb.sv ====
// bench: directed scenarios for the numeric format unit
`timescale 1ns/1ps
module nffu_unit_tb;
  import nffu_pkg::*;
  logic        sys_clk;
  logic        reset;
  logic        go;
  nffu_req_s   go_req;
  logic        req_valid;
  nffu_req_s   req;
  logic        busy;
  logic        done;
  nffu_res_s   result;
  nffu_flags_s flags;
  int          num_errors = 0;
  int          checks = 0;
  int          cycles = 0;

  nffu_unit DUT (.sys_clk(sys_clk), .reset(reset), .req_valid(req_valid), .req(req),
    .busy(busy), .done(done), .result(result), .flags(flags));
  nffu_core_model u_core (.sys_clk(sys_clk), .reset(reset), .go(go), .go_req(go_req),
    .busy(busy), .req_valid(req_valid), .req(req));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic give_verdict();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // scenarios need a few hundred cycles at most
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_flags(input nffu_flags_s exp);
    checks++;
    if (flags !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, flags, exp);
    end
  endtask

  // a and b are register pairs: upper half is the higher numbered register
  task automatic issue(input nffu_op_e op, input logic [31:0] a, input logic [31:0] b);
    int n;
    @(negedge sys_clk);
    go     <= 1'b1;
    go_req <= '{op, a[15:0], a[31:16], b[15:0], b[31:16]};
    @(negedge sys_clk);
    go <= 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (done !== 1'b1 && n < 400);
    if (n >= 400) begin
      num_errors++;
      give_verdict();
    end
  endtask

  task automatic t_int_div();
    issue(op_int_div, 32'h0003_0028, 32'h0);
    cmp16(result.lo, 16'h000d);
    cmp16(result.hi, 16'h0001);
    issue(op_int_div, 32'h0002_fff9, 32'h0);
    cmp16(result.lo, 16'hfffd);
    cmp16(result.hi, 16'hffff);
  endtask

  task automatic t_int_misc();
    issue(op_int_sqrt, 32'h0000_0011, 32'h0);
    cmp16(result.lo, 16'h0004);
    issue(op_int_sqrt, 32'hffff_ffff, 32'h0);
    cmp16(result.lo, 16'hffff);
    issue(op_bin_to_bcd, 32'h0000_3039, 32'h0);
    cmp16(result.lo, 16'h2345);
    cmp16(result.hi, 16'h0001);
    issue(op_bcd_to_bin, 32'h0000_9999, 32'h0);
    cmp16(result.lo, 16'h270f);
    issue(op_point_oct, 32'h0000_0008, 32'h0);
    cmp16(result.lo, 16'h0010);
    issue(op_point_oct, 32'h0000_0040, 32'h0);
    cmp16(result.lo, 16'h0100);
  endtask

  task automatic t_fmul();
    issue(op_float_mul, 32'h40d0_0000, 32'h3f80_0000);
    cmp16(result.hi, 16'h40d0);
    cmp16(result.lo, 16'h0000);
    cmp_flags(3'b000);
    issue(op_float_mul, 32'hc000_0000, 32'h4040_0000);
    cmp16(result.hi, 16'hc0c0);
    issue(op_float_mul, 32'h0080_0000, 32'h3f80_0000);
    cmp16(result.hi, 16'h0080);
    cmp_flags(3'b000);
    issue(op_float_mul, 32'h0000_0000, 32'h4040_0000);
    cmp_flags(3'b100);
    issue(op_float_mul, 32'h7f00_0000, 32'h7f00_0000);
    cmp16(result.hi, 16'h7f7f);
    cmp16(result.lo, 16'hffff);
    cmp_flags(3'b001);
    issue(op_float_mul, 32'h0080_0000, 32'h0080_0000);
    cmp_flags(3'b010);
    issue(op_int_div, 32'h0003_0028, 32'h0);
    cmp_flags(3'b010);
  endtask

  task automatic t_conv();
    issue(op_bin_to_dec_float_convert, 32'h40d0_0000, 32'h0);
    cmp16(result.lo, 16'h1964);
    cmp16(result.hi, 16'hfffd);
    cmp_flags(3'b000);
    issue(op_bin_to_dec_float_convert, 32'hc0c0_0000, 32'h0);
    cmp16(result.lo, 16'he890);
    issue(op_bin_to_dec_float_convert, 32'h3eaa_aaab, 32'h0);
    cmp16(result.lo, 16'h0d05);
    cmp16(result.hi, 16'hfffc);
    issue(op_bin_to_dec_float_convert, 32'h0080_0000, 32'h0);
    cmp16(result.lo, 16'h0497);
    cmp16(result.hi, 16'hffd7);
    issue(op_dec_to_bin_float_convert, 32'h0000_03e8, 32'h0);
    cmp16(result.hi, 16'h447a);
    cmp16(result.lo, 16'h0000);
    issue(op_dec_to_bin_float_convert, 32'h0001_fb2e, 32'h0);
    cmp16(result.hi, 16'hc640);
    cmp16(result.lo, 16'hd000);
  endtask

  initial begin
    reset  = 1'b1;
    go     = 1'b0;
    go_req = '0;
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    t_int_div();
    t_int_misc();
    t_fmul();
    t_conv();
    give_verdict();
  end
endmodule
